// *** design/stpd_drive_cfg.sv ***
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1: Switches set resolution outside software mode.
// R2: All resolution switches on selects software resolution.
// R3: Decode 400, 800, 1600, 3200, 6400 codes.
// R4: Decode remaining codes to the other resolutions.
// R5: Controller must not change resolution while moving.
// R6: Switches set current outside software mode.
// R7: All current switches off selects software current.
// R8: Decode current codes to 2.6 through 7.0 A.
// R9: Reduce to 60 percent after 0.4 s idle.
// R10: Standstill switch on enables reduction.
// R11: Two standstill toggles in 1 s start self-test.
// R12: Act on pulse, direction and enable inputs.
// R13: Green indicator lit while powered.
// R14: Fault lights red and frees the shaft.
// R15: Fault held until power is cycled.
module stpd_drive_cfg #(
    parameter int IDLE_CYC     = stpd_pkg::IDLE_CYC_DEF,
    parameter int TOGGLE_CYC   = stpd_pkg::TOGGLE_CYC_DEF,
    parameter int SELFTEST_CYC = stpd_pkg::SELFTEST_CYC_DEF
) (
    // Clock and power-on reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Switch bank, on reads as 1.
    input  wire logic        cur_sel_bit0,
    input  wire logic        cur_sel_bit1,
    input  wire logic        cur_sel_bit2,
    input  wire logic        standstill_selector,
    input  wire logic        res_sel_bit0,
    input  wire logic        res_sel_bit1,
    input  wire logic        res_sel_bit2,
    input  wire logic        res_sel_bit3,
    // Differential command inputs from the motion controller.
    input  wire logic        step_pulse_in_p,
    input  wire logic        step_pulse_in_n,
    input  wire logic        dir_in_p,
    input  wire logic        dir_in_n,
    input  wire logic        drive_enable_in_p,
    input  wire logic        drive_enable_in_n,
    // Fault report from the power stage.
    input  wire logic        fault_detect,
    // Drive outputs.
    output logic             step_out,
    output logic             dir_out,
    output logic             motor_energize,
    output logic      [15:0] steps_per_rev,
    output logic      [6:0]  peak_current,
    output logic      [6:0]  phase_current,
    output logic             autoconf_busy,
    // Indicators and interrupt.
    output logic             led_green,
    output logic             led_red,
    output logic             irq
);
    import stpd_pkg::*;

    typedef struct packed {
        logic                  fault;
        logic                  reduced;
        logic                  energize;
        logic                  step;
        logic                  dir;
        logic                  step_prev;
        logic                  ss_prev;
        logic [1:0]            warm;
        logic [31:0]           idle_cnt;
        logic [31:0]           ac_cnt;
        stpd_ac_t              ac;
        logic [9:0]            cfg_res;
        logic [6:0]            cfg_cur;
        logic [15:0]           steps;
        logic [6:0]            peak;
        logic [6:0]            phase;
        logic [IRQ_W-1:0]      irq_st;
        logic [IRQ_W-1:0]      irq_en;
        logic [31:0]           rdata;
    } stpd_state_t;

    stpd_state_t s_r;
    stpd_state_t s_nxt;

    logic [11:0] raw;
    logic [11:0] sy;
    logic [3:0]  res_key;
    logic [2:0]  cur_key;
    logic        pulse_lvl;
    logic        dir_lvl;
    logic        en_lvl;
    logic        ss_lvl;
    logic        flt_lvl;
    logic        wr_en;
    logic        mapped;

    // Differential pairs are resolved before the synchroniser; a pair is asserted when p is high and n low.
    assign raw = {fault_detect,
                  drive_enable_in_p & ~drive_enable_in_n,
                  dir_in_p & ~dir_in_n,
                  step_pulse_in_p & ~step_pulse_in_n,
                  standstill_selector,
                  res_sel_bit0, res_sel_bit1, res_sel_bit2, res_sel_bit3,
                  cur_sel_bit0, cur_sel_bit1, cur_sel_bit2};

    stpd_sync #(
        .W (12)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (raw),
        .q       (sy)
    );

    // Keys list bit 0 first, matching the switch table order.
    assign flt_lvl   = sy[11];
    assign en_lvl    = sy[10];
    assign dir_lvl   = sy[9];
    assign pulse_lvl = sy[8];
    assign ss_lvl    = sy[7];
    assign res_key   = sy[6:3];
    assign cur_key   = sy[2:0];

    // Resolution decode; the all-on code is handled by the caller.
    function automatic logic [15:0] decode_res(input logic [3:0] k);
        case (k)
            4'h7:    decode_res = 16'h0190; // R3
            4'hB:    decode_res = 16'h0320; // R3
            4'h3:    decode_res = 16'h0640; // R3
            4'hD:    decode_res = 16'h0C80; // R3
            4'h5:    decode_res = 16'h1900; // R3
            4'h9:    decode_res = 16'h3200; // R4
            4'h1:    decode_res = 16'h6400; // R4
            4'hE:    decode_res = 16'h03E8; // R4
            4'h6:    decode_res = 16'h07D0; // R4
            4'hA:    decode_res = 16'h0FA0; // R4
            4'h2:    decode_res = 16'h1388; // R4
            4'hC:    decode_res = 16'h1F40; // R4
            4'h4:    decode_res = 16'h2710; // R4
            4'h8:    decode_res = 16'h4E20; // R4
            default: decode_res = 16'h61A8; // R4
        endcase
    endfunction

    // Peak current decode in tenths of an ampere; the all-off code is handled by the caller.
    function automatic logic [6:0] decode_cur(input logic [2:0] k);
        case (k)
            3'h4:    decode_cur = 7'h1A; // R8
            3'h2:    decode_cur = 7'h22; // R8
            3'h6:    decode_cur = 7'h28; // R8
            3'h1:    decode_cur = 7'h30; // R8
            3'h5:    decode_cur = 7'h36; // R8
            3'h3:    decode_cur = 7'h3D; // R8
            default: decode_cur = 7'h46; // R8
        endcase
    endfunction

    // Standstill level, rounded down so the reduced current never exceeds the target.
    function automatic logic [6:0] scale_still(input logic [6:0] c);
        logic [13:0] p;
        p = (14'(c) * 14'(REDUCE_PCT)) / 14'(100);
        scale_still = p[6:0];
    endfunction

    // Zero-wait slave: reads are captured in the setup cycle, writes land on the access edge.
    assign pready = 1'b1;
    assign mapped = (paddr == CFG_RES_OFS) || (paddr == CFG_CUR_OFS) || (paddr == STATUS_OFS) ||
                    (paddr == RES_OUT_OFS) || (paddr == CUR_OUT_OFS) || (paddr == IRQ_ST_OFS) ||
                    (paddr == IRQ_CLR_OFS) || (paddr == IRQ_EN_OFS);
    assign pslverr = psel & penable & ~mapped;
    assign wr_en   = psel & penable & pwrite & mapped;

    // Next-state logic for the whole block.
    always_comb begin
        logic [IRQ_W-1:0] ev;
        logic [IRQ_W-1:0] clr;
        logic [9:0]       wres;
        logic [6:0]       wcur;
        ev    = '0;
        clr   = '0;
        wres  = pwdata[9:0];
        wcur  = pwdata[6:0];
        s_nxt = s_r;

        // Once set, nothing but power-on reset removes the fault.
        s_nxt.fault = s_r.fault | flt_lvl; // R14 R15
        s_nxt.energize = en_lvl & ~s_nxt.fault; // R12 R14
        s_nxt.dir = dir_lvl; // R12
        s_nxt.step = pulse_lvl & s_nxt.energize & (s_r.ac != AC_BUSY); // R12
        s_nxt.step_prev = pulse_lvl;
        s_nxt.ss_prev = ss_lvl;

        // The synchroniser leaves reset at 0 whatever the switch says, so its first change is not a toggle.
        if (s_r.warm != 2'h3) begin
            s_nxt.warm = s_r.warm + 2'h1;
        end

        // Idle timer restarts on each new step edge and saturates at the timeout.
        if (pulse_lvl && !s_r.step_prev) begin
            s_nxt.idle_cnt = '0; // R9
        end else if (s_r.idle_cnt != 32'(IDLE_CYC)) begin
            s_nxt.idle_cnt = s_r.idle_cnt + 32'h1; // R9
        end
        s_nxt.reduced = ss_lvl && (s_nxt.idle_cnt == 32'(IDLE_CYC)); // R9 R10

        // Resolution and current selection from switches or software.
        s_nxt.steps = (res_key == RES_KEY_SW) ? {6'h00, s_r.cfg_res} : decode_res(res_key); // R1 R2
        s_nxt.peak = (cur_key == CUR_KEY_SW) ? s_r.cfg_cur : decode_cur(cur_key); // R6 R7
        if (!s_nxt.energize) begin
            s_nxt.phase = 7'h00; // R14
        end else if (s_nxt.reduced) begin
            s_nxt.phase = scale_still(s_nxt.peak); // R9
        end else begin
            s_nxt.phase = s_nxt.peak;
        end

        // A second toggle inside the window starts self-test; toggles while busy are ignored.
        case (s_r.ac)
            AC_IDLE: begin
                if ((s_r.warm == 2'h3) && (ss_lvl != s_r.ss_prev)) begin // R11
                    s_nxt.ac     = AC_ARMED;
                    s_nxt.ac_cnt = '0;
                end
            end
            AC_ARMED: begin
                if (ss_lvl != s_r.ss_prev) begin
                    s_nxt.ac     = AC_BUSY; // R11
                    s_nxt.ac_cnt = '0;
                    ev[IRQ_AUTOCONF] = 1'b1;
                end else if (s_r.ac_cnt == 32'(TOGGLE_CYC - 1)) begin
                    s_nxt.ac = AC_IDLE;
                end else begin
                    s_nxt.ac_cnt = s_r.ac_cnt + 32'h1;
                end
            end
            AC_BUSY: begin
                if (s_r.ac_cnt == 32'(SELFTEST_CYC - 1)) begin
                    s_nxt.ac = AC_IDLE;
                end else begin
                    s_nxt.ac_cnt = s_r.ac_cnt + 32'h1;
                end
            end
            default: begin
                s_nxt.ac = AC_IDLE;
            end
        endcase

        // Register writes; values outside the allowed range are clamped.
        if (wr_en) begin
            case (paddr)
                CFG_RES_OFS: begin
                    s_nxt.cfg_res = (wres < RES_MIN) ? RES_MIN : ((wres > RES_MAX) ? RES_MAX : wres); // R2
                end
                CFG_CUR_OFS: begin
                    s_nxt.cfg_cur = (wcur < CUR_MIN) ? CUR_MIN : ((wcur > CUR_MAX) ? CUR_MAX : wcur); // R7
                end
                IRQ_CLR_OFS: clr = pwdata[IRQ_W-1:0];
                IRQ_EN_OFS:  s_nxt.irq_en = pwdata[IRQ_W-1:0];
                default:     clr = '0;
            endcase
        end

        // A new event beats a clear in the same cycle.
        ev[IRQ_FAULT] = s_nxt.fault & ~s_r.fault;
        ev[IRQ_STILL] = s_nxt.reduced & ~s_r.reduced;
        s_nxt.irq_st  = (s_r.irq_st & ~clr) | ev;

        // Read data is captured during the setup cycle so it is stable for the access edge.
        if (psel && !penable) begin
            case (paddr)
                CFG_RES_OFS: s_nxt.rdata = {22'h000000, s_r.cfg_res};
                CFG_CUR_OFS: s_nxt.rdata = {25'h0000000, s_r.cfg_cur};
                STATUS_OFS:  s_nxt.rdata = {25'h0000000, s_r.dir, (cur_key == CUR_KEY_SW),
                                            (res_key == RES_KEY_SW), s_r.energize,
                                            (s_r.ac == AC_BUSY), s_r.reduced, s_r.fault};
                RES_OUT_OFS: s_nxt.rdata = {16'h0000, s_r.steps};
                CUR_OUT_OFS: s_nxt.rdata = {17'h00000, s_r.phase, 1'b0, s_r.peak};
                IRQ_ST_OFS:  s_nxt.rdata = {29'h00000000, s_r.irq_st};
                IRQ_EN_OFS:  s_nxt.rdata = {29'h00000000, s_r.irq_en};
                default:     s_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    // Single state register; presetn is the power-on reset and the only way out of a fault.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r         <= '0;
            s_r.ac      <= AC_IDLE;
            s_r.cfg_res <= CFG_RES_RST;
            s_r.cfg_cur <= CFG_CUR_RST;
            s_r.irq_st  <= IRQ_RST;
            s_r.irq_en  <= IRQ_RST;
        end else begin
            s_r <= s_nxt; // R15
        end
    end

    // Outputs from the state register; led_green is tied high.
    assign prdata         = s_r.rdata;
    assign step_out       = s_r.step;
    assign dir_out        = s_r.dir;
    assign motor_energize = s_r.energize;
    assign steps_per_rev  = s_r.steps;
    assign peak_current   = s_r.peak;
    assign phase_current  = s_r.phase;
    assign autoconf_busy  = (s_r.ac == AC_BUSY);
    assign led_red        = s_r.fault; // R14
    assign led_green      = 1'b1; // R13
    assign irq            = |(s_r.irq_st & s_r.irq_en);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_res_400;
        res_key == 4'h7 |=> steps_per_rev == 16'h0190;
    endproperty
    a_res_400: assert property (p_res_400) else $error("resolution code 0111 not 400"); // R3

    property p_res_sw;
        res_key == RES_KEY_SW |=> steps_per_rev == {6'h00, $past(s_r.cfg_res)};
    endproperty
    a_res_sw: assert property (p_res_sw) else $error("software resolution not used"); // R2

    property p_res_25000;
        res_key == 4'h0 |=> steps_per_rev == 16'h61A8;
    endproperty
    a_res_25000: assert property (p_res_25000) else $error("resolution code 0000 not 25000"); // R4

    property p_res_6400;
        res_key == 4'h5 |=> steps_per_rev == 16'h1900;
    endproperty
    a_res_6400: assert property (p_res_6400) else $error("resolution code 0101 not 6400"); // R1

    property p_cur_max;
        cur_key == 3'h7 ##1 cur_key == 3'h7 |-> peak_current == 7'h46;
    endproperty
    a_cur_max: assert property (p_cur_max) else $error("current code 111 not 7.0 A"); // R8

    property p_cur_48;
        cur_key == 3'h1 |=> peak_current == 7'h30;
    endproperty
    a_cur_48: assert property (p_cur_48) else $error("current code 001 not 4.8 A"); // R6

    property p_cur_sw;
        cur_key == CUR_KEY_SW |=> peak_current == $past(s_r.cfg_cur);
    endproperty
    a_cur_sw: assert property (p_cur_sw) else $error("software current not used"); // R7

    property p_still_level;
        s_r.reduced && motor_energize |-> phase_current == scale_still(peak_current) &&
                                          s_r.idle_cnt == 32'(IDLE_CYC);
    endproperty
    a_still_level: assert property (p_still_level) else $error("standstill current wrong"); // R9

    property p_still_off;
        !ss_lvl |=> !s_r.reduced && (!motor_energize || phase_current == peak_current);
    endproperty
    a_still_off: assert property (p_still_off) else $error("reduced with selector off"); // R10

    property p_autoconf;
        s_r.ac == AC_ARMED && ss_lvl != s_r.ss_prev |=> autoconf_busy ##1 autoconf_busy;
    endproperty
    a_autoconf: assert property (p_autoconf) else $error("second toggle did not start self-test"); // R11

    property p_enable;
        !en_lvl |=> !motor_energize && !step_out;
    endproperty
    a_enable: assert property (p_enable) else $error("disabled drive still energised"); // R12

    property p_fault_free;
        s_r.fault |-> !motor_energize && led_red && phase_current == 7'h00;
    endproperty
    a_fault_free: assert property (p_fault_free) else $error("fault state not freeing shaft"); // R14

    property p_fault_hold;
        led_red |=> led_red [*3];
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault state cleared"); // R15

    c_autoconf: cover property (s_r.ac == AC_ARMED ##1 autoconf_busy);
    c_reduced:  cover property (!s_r.reduced ##1 s_r.reduced);
    c_fault:    cover property (!led_red ##1 led_red);
    c_sw_mode:  cover property (res_key == RES_KEY_SW && cur_key == CUR_KEY_SW);

endmodule

`default_nettype wire

// *** include/stpd_pkg.sv ***
package stpd_pkg;

    // Clock rate and the documented times, each with its derived cycle count.
    localparam int CLK_KHZ          = 40000;
    localparam int IDLE_MS          = 400;
    localparam int IDLE_CYC_DEF     = IDLE_MS * CLK_KHZ;
    localparam int TOGGLE_MS        = 1000;
    localparam int TOGGLE_CYC_DEF   = TOGGLE_MS * CLK_KHZ;
    localparam int SELFTEST_US      = 1000;
    localparam int SELFTEST_CYC_DEF = (SELFTEST_US * CLK_KHZ) / 1000;

    // Register byte offsets.
    localparam logic [7:0] CFG_RES_OFS = 8'h00;
    localparam logic [7:0] CFG_CUR_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS  = 8'h08;
    localparam logic [7:0] RES_OUT_OFS = 8'h0C;
    localparam logic [7:0] CUR_OUT_OFS = 8'h10;
    localparam logic [7:0] IRQ_ST_OFS  = 8'h14;
    localparam logic [7:0] IRQ_CLR_OFS = 8'h18;
    localparam logic [7:0] IRQ_EN_OFS  = 8'h1C;

    // Software configured limits and reset values.
    localparam logic [9:0] RES_MIN     = 10'h001;
    localparam logic [9:0] RES_MAX     = 10'h200;
    localparam logic [9:0] CFG_RES_RST = 10'h001;
    localparam logic [6:0] CUR_MIN     = 7'h05;
    localparam logic [6:0] CUR_MAX     = 7'h46;
    localparam logic [6:0] CFG_CUR_RST = 7'h05;

    // Switch codes that hand control to software.
    localparam logic [3:0] RES_KEY_SW = 4'hF;
    localparam logic [2:0] CUR_KEY_SW = 3'h0;

    // Standstill scaling, percent.
    localparam int REDUCE_PCT = 60;

    // Status bit positions.
    localparam int ST_FAULT    = 0;
    localparam int ST_REDUCED  = 1;
    localparam int ST_BUSY     = 2;
    localparam int ST_ENERGIZE = 3;
    localparam int ST_SW_RES   = 4;
    localparam int ST_SW_CUR   = 5;
    localparam int ST_DIR      = 6;

    // Interrupt bit positions.
    localparam int IRQ_W        = 3;
    localparam int IRQ_FAULT    = 0;
    localparam int IRQ_AUTOCONF = 1;
    localparam int IRQ_STILL    = 2;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

    // Auto-configuration sequencer states.
    typedef enum logic [2:0] {
        AC_IDLE  = 3'b001,
        AC_ARMED = 3'b010,
        AC_BUSY  = 3'b100
    } stpd_ac_t;

endpackage

// *** design/stpd_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for a bank of asynchronous levels.
module stpd_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Levels.
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    // The first stage feeds only the second; nothing else may look at it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

`default_nettype wire

// *** dv/stpd_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Motion controller model; each command drives a true and complement pair.
module stpd_ctrl_model (
    // Clock.
    input  wire logic pclk,
    // Differential command pairs.
    output logic      step_p,
    output logic      step_n,
    output logic      dir_p,
    output logic      dir_n,
    output logic      ena_p,
    output logic      ena_n
);
    logic pul_r = 1'b0;
    logic dir_r = 1'b0;
    logic ena_r = 1'b0;

    // Both wires of a pair are always driven, so no pair floats.
    assign step_p = pul_r;
    assign step_n = ~pul_r;
    assign dir_p  = dir_r;
    assign dir_n  = ~dir_r;
    assign ena_p  = ena_r;
    assign ena_n  = ~ena_r;

    // Levels change only just after a rising edge.
    task automatic put(input logic p, input logic d, input logic e);
        @(posedge pclk);
        pul_r <= p;
        dir_r <= d;
        ena_r <= e;
    endtask
endmodule

`default_nettype wire

// *** dv/stpd_drive_cfg_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module stpd_drive_cfg_tb;
    import stpd_pkg::*;

    // Short counts keep the run brief.
    localparam int IDLE = 50;
    localparam int TOG  = 100;
    localparam int STC  = 20;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        c0, c1, c2, still, r0, r1, r2, r3, fault_detect;
    logic        sp, sn, dp, dn, ep, en;
    logic        step_out, dir_out, motor_energize, autoconf_busy, led_green, led_red, irq;
    logic [15:0] steps_per_rev;
    logic [6:0]  peak_current, phase_current;
    int          fails, compares;
    logic [15:0] res_tab [16] = '{16'h61A8, 16'h6400, 16'h1388, 16'h0640, 16'h2710, 16'h1900, 16'h07D0,
        16'h0190, 16'h4E20, 16'h3200, 16'h0FA0, 16'h0320, 16'h1F40, 16'h0C80, 16'h03E8, 16'h0200};
    logic [6:0]  cur_tab [8] = '{7'h46, 7'h30, 7'h22, 7'h3D, 7'h1A, 7'h36, 7'h28, 7'h46};

    stpd_drive_cfg #(.IDLE_CYC(IDLE), .TOGGLE_CYC(TOG), .SELFTEST_CYC(STC)) dut_u (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cur_sel_bit0(c0), .cur_sel_bit1(c1), .cur_sel_bit2(c2), .standstill_selector(still),
        .res_sel_bit0(r0), .res_sel_bit1(r1), .res_sel_bit2(r2), .res_sel_bit3(r3),
        .step_pulse_in_p(sp), .step_pulse_in_n(sn), .dir_in_p(dp), .dir_in_n(dn),
        .drive_enable_in_p(ep), .drive_enable_in_n(en), .fault_detect(fault_detect),
        .step_out(step_out), .dir_out(dir_out), .motor_energize(motor_energize),
        .steps_per_rev(steps_per_rev), .peak_current(peak_current), .phase_current(phase_current),
        .autoconf_busy(autoconf_busy), .led_green(led_green), .led_red(led_red), .irq(irq));

    stpd_ctrl_model mdl_u (.pclk(pclk), .step_p(sp), .step_n(sn), .dir_p(dp), .dir_n(dn),
        .ena_p(ep), .ena_n(en));

    // Free-running bus clock.
    always #12.5 pclk = ~pclk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // One APB transfer; the request holds until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Switch keys are packed as the design reads them, bit 0 first.
    task automatic sw(input logic [3:0] rk, input logic [2:0] ck, input logic s);
        @(posedge pclk);
        {r0, r1, r2, r3} <= rk;
        {c0, c1, c2} <= ck;
        still <= s;
        tick(4);
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // A hang is cut short well after the few hundred cycles the tests need.
    initial begin
        #(25 * 20000);
        fails++;
        summarize();
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, fault_detect} = '0;
        {c0, c1, c2, r0, r1, r2, r3} = '0;
        still = 1'b1;
        fails = 0;
        compares = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        tick(1);
        chk("led_green", 32'h1, 32'(led_green));
        apb(0, CFG_RES_OFS, 0);
        chk("cfg_res", 32'h1, rd);
        apb(0, 8'h40, 0);
        chk("unmapped_err", 32'h1, 32'(err));
        $display("Test reset done");
        // The motor stays still while switches change.
        apb(1, CFG_RES_OFS, 32'h3FF);
        apb(0, CFG_RES_OFS, 0);
        chk("res_clamp", 32'h200, rd);
        for (int k = 0; k < 16; k++) begin
            sw(k[3:0], 3'h7, 1'b1);
            chk("steps_per_rev", 32'(res_tab[k]), 32'(steps_per_rev));
        end
        apb(1, CFG_CUR_OFS, 32'h64);
        for (int k = 0; k < 8; k++) begin
            sw(4'h7, k[2:0], 1'b1);
            chk("peak_current", 32'(cur_tab[k]), 32'(peak_current));
        end
        $display("Test switch tables done");
        mdl_u.put(1'b0, 1'b1, 1'b1);
        tick(5);
        chk("energize", 32'h1, 32'(motor_energize));
        chk("dir_out", 32'h1, 32'(dir_out));
        mdl_u.put(1'b1, 1'b1, 1'b1);
        tick(4);
        chk("step_out", 32'h1, 32'(step_out));
        mdl_u.put(1'b0, 1'b0, 1'b1);
        apb(1, IRQ_CLR_OFS, 32'h7);
        tick(8);
        chk("step_low", 32'h0, 32'(step_out));
        chk("dir_low", 32'h0, 32'(dir_out));
        chk("phase_full", 32'h46, 32'(phase_current));
        tick(IDLE);
        chk("phase_reduced", 32'h2A, 32'(phase_current));
        apb(0, IRQ_ST_OFS, 0);
        chk("irq_st_still", 32'h1, 32'(rd[IRQ_STILL]));
        chk("irq_masked", 32'h0, 32'(irq));
        apb(1, IRQ_EN_OFS, 32'h4);
        tick(2);
        chk("irq_on", 32'h1, 32'(irq));
        apb(1, IRQ_CLR_OFS, 32'h4);
        tick(2);
        chk("irq_cleared", 32'h0, 32'(irq));
        $display("Test standstill done");
        sw(4'h7, 3'h7, 1'b0);
        sw(4'h7, 3'h7, 1'b1);
        tick(3);
        chk("selftest_busy", 32'h1, 32'(autoconf_busy));
        mdl_u.put(1'b1, 1'b0, 1'b1);
        tick(4);
        chk("step_blocked", 32'h0, 32'(step_out));
        mdl_u.put(1'b0, 1'b0, 1'b1);
        tick(STC + 5);
        chk("selftest_end", 32'h0, 32'(autoconf_busy));
        sw(4'h7, 3'h7, 1'b0);
        tick(TOG + 20);
        chk("phase_kept_full", 32'h46, 32'(phase_current));
        // A toggle after the window has closed only arms a new one.
        sw(4'h7, 3'h7, 1'b1);
        chk("single_toggle", 32'h0, 32'(autoconf_busy));
        $display("Test self-test done");
        @(posedge pclk);
        fault_detect <= 1'b1;
        tick(5);
        chk("led_red", 32'h1, 32'(led_red));
        chk("fault_free", 32'h0, 32'(motor_energize));
        chk("fault_phase", 32'h0, 32'(phase_current));
        @(posedge pclk);
        fault_detect <= 1'b0;
        mdl_u.put(1'b0, 1'b0, 1'b0);
        mdl_u.put(1'b0, 1'b0, 1'b1);
        tick(10);
        chk("red_held", 32'h1, 32'(led_red));
        chk("still_free", 32'h0, 32'(motor_energize));
        apb(0, STATUS_OFS, 0);
        chk("status_fault", 32'h1, 32'(rd[ST_FAULT]));
        apb(0, IRQ_ST_OFS, 0);
        chk("irq_st_fault", 32'h1, 32'(rd[IRQ_FAULT]));
        chk("irq_st_autoconf", 32'h1, 32'(rd[IRQ_AUTOCONF]));
        $display("Test fault done");
        // Only a power cycle leaves the fault; a single toggle right after it must not start self-test.
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        tick(4);
        chk("red_cleared", 32'h0, 32'(led_red));
        sw(4'hF, 3'h0, 1'b0);
        chk("steps_sw_reset", 32'h1, 32'(steps_per_rev));
        chk("peak_sw_reset", 32'h5, 32'(peak_current));
        chk("no_false_arm", 32'h0, 32'(autoconf_busy));
        $display("Test power cycle done");
        summarize();
    end
endmodule

`default_nettype wire
